// ### inc/owb_params.svh
// Constants for the single-wire read-byte and triplet engine.
`ifndef OWB_PARAMS_SVH
`define OWB_PARAMS_SVH
// ==========================================================
// Clock and timing figures
`define OWB_CLK_PERIOD_PS 25000
`define OWB_START_MAX_PS 262500
`define OWB_SLOT_STD_NS 65000
`define OWB_SLOT_OD_NS 9000
`define OWB_LOW1_STD_NS 8000
`define OWB_LOW1_OD_NS 1000
`define OWB_LOW0_STD_NS 60000
`define OWB_LOW0_OD_NS 7500
`define OWB_SMP_STD_NS 14000
`define OWB_SMP_OD_NS 2000
`define OWB_APU_NS 2500
// ==========================================================
// Command codes
`define OWB_CODE_RBYTE 8'h96
`define OWB_CODE_TRIP 8'h78
// ==========================================================
// Register offsets
`define OWB_OFS_CMD 3'h0
`define OWB_OFS_PTR 3'h1
`define OWB_OFS_PORT 3'h2
`define OWB_OFS_CFG 3'h3
`define OWB_OFS_STAT 3'h4
// ==========================================================
// Field positions and reset values
`define OWB_STAT_BUSY 0
`define OWB_STAT_NACK 1
`define OWB_STAT_SBR 5
`define OWB_STAT_TSB 6
`define OWB_STAT_DIR 7
`define OWB_CFG_SPEED 0
`define OWB_CFG_APU 1
`define OWB_DIRV_BIT 7
`define OWB_PTR_STATUS 1'b0
`define OWB_PTR_RDATA 1'b1
`define OWB_CFG_RST 2'h0
`define OWB_RDATA_RST 8'h00
`endif

// ### inc/owb_pkg.sv
// Types shared by the single-wire read-byte and triplet engine.
package owb_pkg;
  typedef enum {ST_IDLE, ST_CLK_RISE, ST_CLK_FALL, ST_SLOT} owb_state_t;
  typedef enum {OP_RBYTE, OP_TRIP} owb_op_t;
  typedef logic [11:0] owb_cnt_t;
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } owb_req_t;
  typedef struct packed {
    logic o;
    logic oe;
  } owb_pin_t;
  typedef struct packed {
    owb_state_t st;
    owb_op_t op;
    logic [1:0] scl_s;
    logic scl_d;
    logic [1:0] sda_s;
    logic [1:0] ow_s;
    logic busy;
    logic nack;
    logic ack;
    logic ptr;
    logic speed;
    logic active_pullup_select;
    logic single_bit_result;
    logic second_bit_flag;
    logic dir;
    logic dir_v;
    logic [7:0] shift;
    logic [7:0] rd_reg;
    logic [2:0] idx;
    owb_cnt_t cnt;
    logic [7:0] rdata;
    owb_pin_t pin;
  } owb_regs_t;
endpackage

// ### rtl/owb_engine.sv
// Single-wire read-byte and triplet command engine with its register port.
// ==========================================================
// Behaviour
// - Code 96h runs eight read slots, stores byte
// - Each read slot is a write-one slot
// - Commands only processed once bus is idle
// - Busy at read-byte code: no ack, ignored
// - Read-byte lasts eight slots plus 262.5ns
// - Read-byte activity starts within 262.5ns
// - Busy flag high for eight slot times
// - Pointer to status; host re-points for data
// - Code 78h: two read slots, one write
// - Reads 00: write slot follows direction bit
// - Reads 01 write zero, 10 write one
// - Reads 11 (error) write one
// - Busy at triplet code: no ack, ignored
// - Triplet lasts three slots plus 262.5ns
// - Triplet activity starts within 262.5ns of MSB
// - Busy flag high for three slot times
// - Result flag first sample, second-bit flag second sample
// - Pointer to status after triplet
// - Direction value is bit 7 only
// - Repeated reads return selected register
`timescale 1ns/1ps
`default_nettype none
`include "owb_params.svh"
module owb_engine #(
  parameter int SLOT_STD_NS = `OWB_SLOT_STD_NS,
  parameter int SLOT_OD_NS = `OWB_SLOT_OD_NS,
  parameter int LOW1_STD_NS = `OWB_LOW1_STD_NS,
  parameter int LOW1_OD_NS = `OWB_LOW1_OD_NS,
  parameter int LOW0_STD_NS = `OWB_LOW0_STD_NS,
  parameter int LOW0_OD_NS = `OWB_LOW0_OD_NS,
  parameter int SMP_STD_NS = `OWB_SMP_STD_NS,
  parameter int SMP_OD_NS = `OWB_SMP_OD_NS,
  parameter int APU_NS = `OWB_APU_NS
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire owb_pkg::owb_req_t req,
  output logic [7:0] rdata,
  output logic cmd_ack,
  output logic busy,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic ow_in,
  output owb_pkg::owb_pin_t ow_pin
);
  import owb_pkg::*;

  // ==========================================================
  // Timing in clock cycles
  // Least times round up; the slot figures are all least times.
  localparam int SLOT_STD_C = (SLOT_STD_NS * 1000 + `OWB_CLK_PERIOD_PS - 1) / `OWB_CLK_PERIOD_PS;
  localparam int SLOT_OD_C = (SLOT_OD_NS * 1000 + `OWB_CLK_PERIOD_PS - 1) / `OWB_CLK_PERIOD_PS;
  localparam int LOW1_STD_C = (LOW1_STD_NS * 1000 + `OWB_CLK_PERIOD_PS - 1) / `OWB_CLK_PERIOD_PS;
  localparam int LOW1_OD_C = (LOW1_OD_NS * 1000 + `OWB_CLK_PERIOD_PS - 1) / `OWB_CLK_PERIOD_PS;
  localparam int LOW0_STD_C = (LOW0_STD_NS * 1000 + `OWB_CLK_PERIOD_PS - 1) / `OWB_CLK_PERIOD_PS;
  localparam int LOW0_OD_C = (LOW0_OD_NS * 1000 + `OWB_CLK_PERIOD_PS - 1) / `OWB_CLK_PERIOD_PS;
  localparam int SMP_STD_C = (SMP_STD_NS * 1000 + `OWB_CLK_PERIOD_PS - 1) / `OWB_CLK_PERIOD_PS;
  localparam int SMP_OD_C = (SMP_OD_NS * 1000 + `OWB_CLK_PERIOD_PS - 1) / `OWB_CLK_PERIOD_PS;
  localparam int APU_C = (APU_NS * 1000 + `OWB_CLK_PERIOD_PS - 1) / `OWB_CLK_PERIOD_PS;
  // Longest start delay rounds down; the pin synchronisers use two of these cycles.
  localparam int START_MAX_C = `OWB_START_MAX_PS / `OWB_CLK_PERIOD_PS;

  // Counts must fit the 12-bit slot counter and keep the sample inside the slot.
  if (SLOT_STD_C >= 4096 || SLOT_OD_C >= 4096)
  begin : g_chk_cnt
    $error("slot time does not fit the slot counter");
  end
  if (LOW0_STD_C >= SMP_STD_C + SLOT_STD_C || SMP_STD_C >= SLOT_STD_C || SMP_OD_C >= SLOT_OD_C)
  begin : g_chk_smp
    $error("sample point lies outside the slot");
  end
  if (LOW1_STD_C >= SMP_STD_C || LOW1_OD_C >= SMP_OD_C || START_MAX_C < 4)
  begin : g_chk_low
    $error("slot low time or start delay cannot be served");
  end

  // ==========================================================
  // Slot timing lookup
  // speed selects timing
  function automatic owb_cnt_t slot_c(input logic od);
    slot_c = od ? owb_cnt_t'(SLOT_OD_C) : owb_cnt_t'(SLOT_STD_C);
  endfunction

  function automatic owb_cnt_t low_c(input logic od, input logic wbit);
    if (wbit)
    begin
      low_c = od ? owb_cnt_t'(LOW1_OD_C) : owb_cnt_t'(LOW1_STD_C);
    end
    else
    begin
      low_c = od ? owb_cnt_t'(LOW0_OD_C) : owb_cnt_t'(LOW0_STD_C);
    end
  endfunction

  function automatic owb_cnt_t smp_c(input logic od);
    smp_c = od ? owb_cnt_t'(SMP_OD_C) : owb_cnt_t'(SMP_STD_C);
  endfunction

  // ==========================================================
  // State
  owb_regs_t state_reg;
  owb_regs_t state_next;

  logic scl_fall;
  logic scl_rise;
  logic ow_bit;
  logic wbit;
  logic last_slot;
  logic [7:0] status;
  owb_cnt_t low_t;

  // Only the second stage of each synchroniser is looked at.
  assign scl_fall = state_reg.scl_d & ~state_reg.scl_s[1];
  assign scl_rise = ~state_reg.scl_d & state_reg.scl_s[1];
  assign ow_bit = state_reg.ow_s[1];
  assign last_slot = (state_reg.op == OP_RBYTE) ? (state_reg.idx == 3'd7) : (state_reg.idx == 3'd2);
  assign wbit = (state_reg.op == OP_TRIP && state_reg.idx == 3'd2) ? state_reg.dir : 1'b1;
  assign low_t = low_c(state_reg.speed, wbit);

  always_comb
  begin
    status = 8'h00;
    status[`OWB_STAT_BUSY] = state_reg.busy;
    status[`OWB_STAT_NACK] = state_reg.nack;
    status[`OWB_STAT_SBR] = state_reg.single_bit_result;
    status[`OWB_STAT_TSB] = state_reg.second_bit_flag;
    status[`OWB_STAT_DIR] = state_reg.dir;
  end

  always_comb
  begin
    state_next = state_reg;
    state_next.ack = 1'b0;
    state_next.rdata = 8'h00;
    state_next.scl_s = {state_reg.scl_s[0], scl_in};
    state_next.scl_d = state_reg.scl_s[1];
    state_next.sda_s = {state_reg.sda_s[0], sda_in};
    state_next.ow_s = {state_reg.ow_s[0], ow_in};
    state_next.pin = '{o: 1'b1, oe: 1'b0};

    // ==========================================================
    // Register port
    if (req.rd)
    begin
      unique case (req.addr)
        `OWB_OFS_PORT: state_next.rdata = (state_reg.ptr == `OWB_PTR_RDATA) ? state_reg.rd_reg : status;
        `OWB_OFS_CFG: state_next.rdata = {6'h00, state_reg.active_pullup_select, state_reg.speed};
        `OWB_OFS_STAT: state_next.rdata = status;
        `OWB_OFS_PTR: state_next.rdata = {7'h00, state_reg.ptr};
        default: state_next.rdata = 8'h00;
      endcase
    end
    if (req.wr && req.addr == `OWB_OFS_CFG)
    begin
      state_next.speed = req.wdata[`OWB_CFG_SPEED];
      state_next.active_pullup_select = req.wdata[`OWB_CFG_APU];
    end
    if (req.wr && req.addr == `OWB_OFS_PTR)
    begin
      state_next.ptr = req.wdata[0];
    end
    if (req.wr && req.addr == `OWB_OFS_CMD)
    begin
      if (state_reg.busy || state_reg.st != ST_IDLE)
      begin
        state_next.nack = 1'b1;
      end
      else if (req.wdata == `OWB_CODE_RBYTE || req.wdata == `OWB_CODE_TRIP)
      begin
        state_next.nack = 1'b0;
        state_next.ack = 1'b1;
        state_next.op = (req.wdata == `OWB_CODE_RBYTE) ? OP_RBYTE : OP_TRIP;
        state_next.ptr = `OWB_PTR_STATUS;
        state_next.st = ST_CLK_RISE;
      end
      else
      begin
        state_next.nack = 1'b1;
      end
    end

    // ==========================================================
    // Command sequencing
    unique case (state_reg.st)
      ST_IDLE:
      begin
      end
      ST_CLK_RISE:
      begin
        // Rise of the acknowledge clock, or of the direction MSB clock.
        if (scl_rise)
        begin
          state_next.dir_v = state_reg.sda_s[1];
          state_next.st = ST_CLK_FALL;
        end
      end
      ST_CLK_FALL:
      begin
        if (scl_fall)
        begin
          state_next.st = ST_SLOT;
          state_next.busy = 1'b1;
          state_next.idx = 3'd0;
          state_next.cnt = '0;
        end
      end
      ST_SLOT:
      begin
        state_next.cnt = state_reg.cnt + owb_cnt_t'(1);
        if (state_reg.cnt < low_t)
        begin
          state_next.pin = '{o: 1'b0, oe: 1'b1};
        end
        else if (state_reg.active_pullup_select && ow_bit && state_reg.cnt < low_t + owb_cnt_t'(APU_C))
        begin
          state_next.pin = '{o: 1'b1, oe: 1'b1};
        end
        if (state_reg.cnt == smp_c(state_reg.speed))
        begin
          if (state_reg.op == OP_RBYTE)
          begin
            state_next.shift = {ow_bit, state_reg.shift[7:1]};
          end
          else if (state_reg.idx == 3'd0)
          begin
            state_next.single_bit_result = ow_bit;
          end
          else if (state_reg.idx == 3'd1)
          begin
            state_next.second_bit_flag = ow_bit;
            state_next.dir = (state_reg.single_bit_result ^ ow_bit) ? state_reg.single_bit_result : (state_reg.single_bit_result | state_reg.dir_v);
          end
        end
        if (state_reg.cnt == slot_c(state_reg.speed) - owb_cnt_t'(1))
        begin
          state_next.cnt = '0;
          state_next.idx = state_reg.idx + 3'd1;
          if (last_slot)
          begin
            state_next.busy = 1'b0;
            state_next.st = ST_IDLE;
            if (state_reg.op == OP_RBYTE)
            begin
              state_next.rd_reg = state_reg.shift;
            end
          end
        end
      end
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_reg <= '0;
      state_reg.st <= ST_IDLE;
      state_reg.op <= OP_RBYTE;
      state_reg.scl_s <= 2'b11;
      state_reg.scl_d <= 1'b1;
      state_reg.sda_s <= 2'b11;
      state_reg.ow_s <= 2'b11;
      state_reg.ptr <= `OWB_PTR_STATUS;
      {state_reg.active_pullup_select, state_reg.speed} <= `OWB_CFG_RST;
      state_reg.rd_reg <= `OWB_RDATA_RST;
      state_reg.pin <= '{o: 1'b1, oe: 1'b0};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign rdata = state_reg.rdata;
  assign cmd_ack = state_reg.ack;
  assign busy = state_reg.busy;
  assign ow_pin = state_reg.pin;
endmodule
`default_nettype wire

// ### dv/owb_chk_assertions.sv
// Port checker of the read-byte and triplet engine.
`timescale 1ns/1ps
`default_nettype none
`include "owb_params.svh"
module owb_chk #(
  parameter int SLOT_STD_NS = 65000,
  parameter int LOW1_STD_NS = 8000,
  parameter int LOW0_STD_NS = 60000,
  parameter int SLOT_OD_NS = 9000,
  parameter int LOW1_OD_NS = 1000,
  parameter int LOW0_OD_NS = 7500
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire owb_pkg::owb_req_t req,
  input wire logic [7:0] rdata,
  input wire logic cmd_ack,
  input wire logic busy,
  input wire logic scl_in,
  input wire owb_pkg::owb_pin_t ow_pin
);
  import owb_pkg::*;
  // The speed bit is not visible here, so counts of either speed are taken.
  localparam int SC = SLOT_STD_NS / 25;
  localparam int L1 = LOW1_STD_NS / 25;
  localparam int L0 = LOW0_STD_NS / 25;
  localparam int SO = SLOT_OD_NS / 25;
  localparam int L1O = LOW1_OD_NS / 25;
  localparam int L0O = LOW0_OD_NS / 25;
  logic lo, scl_q;
  logic [15:0] bcnt;
  logic [11:0] lcnt;
  logic [7:0] age;
  assign lo = ow_pin.oe && !ow_pin.o;
  always_ff @(posedge sys_clk)
  begin
    scl_q <= scl_in;
    bcnt <= busy ? bcnt + 16'h1 : 16'h0;
    lcnt <= lo ? lcnt + 12'h001 : 12'h000;
    if (!rst_n || (scl_q && !scl_in))
      age <= rst_n ? 8'h00 : 8'hff;
    else if (age != 8'hff)
      age <= age + 8'h1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_drv;
    ow_pin.oe && !ow_pin.o;
  endsequence
  property p_ack_cause;
    cmd_ack |-> $past(req.wr) && $past(req.addr) == `OWB_OFS_CMD && !$past(busy)
      && ($past(req.wdata) == `OWB_CODE_RBYTE || $past(req.wdata) == `OWB_CODE_TRIP);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without accepted code");
  property p_refuse;
    req.wr && req.addr == `OWB_OFS_CMD && busy |=> !cmd_ack;
  endproperty
  a_refuse: assert property (p_refuse) else $error("code acked while busy");
  property p_busy_len;
    $fell(busy) && $past(rst_n) |-> bcnt == 16'(8 * SC) || bcnt == 16'(3 * SC)
      || bcnt == 16'(8 * SO) || bcnt == 16'(3 * SO);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  property p_start;
    $rose(busy) |-> age <= 8'd8 ##1 s_drv;
  endproperty
  a_start: assert property (p_start) else $error("slot start late");
  property p_low_len;
    $fell(lo) && $past(rst_n) |-> lcnt == 12'(L1) || lcnt == 12'(L0) || lcnt == 12'(L1O) || lcnt == 12'(L0O);
  endproperty
  a_low_len: assert property (p_low_len) else $error("low time wrong");
  property p_idle_drv;
    s_drv |-> busy;
  endproperty
  a_idle_drv: assert property (p_idle_drv) else $error("line driven while idle");
  property p_stat_busy;
    $past(req.rd) && $past(req.addr) == `OWB_OFS_STAT |-> rdata[0] == $past(busy);
  endproperty
  a_stat_busy: assert property (p_stat_busy) else $error("status busy wrong");
  property p_busy_hold;
    $rose(busy) |-> busy [*8];
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
endmodule
bind owb_engine owb_chk #(.SLOT_STD_NS(SLOT_STD_NS), .LOW1_STD_NS(LOW1_STD_NS), .LOW0_STD_NS(LOW0_STD_NS),
  .SLOT_OD_NS(SLOT_OD_NS), .LOW1_OD_NS(LOW1_OD_NS), .LOW0_OD_NS(LOW0_OD_NS))
  u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .req(req), .rdata(rdata), .cmd_ack(cmd_ack), .busy(busy),
  .scl_in(scl_in), .ow_pin(ow_pin));
`default_nettype wire

// ### dv/owb_slave.sv
// Behavioural far-end slave answering read slots from a bit pattern.
`timescale 1ns/1ps
`default_nettype none
module owb_slave (
  input wire logic sys_clk,
  input wire owb_pkg::owb_pin_t ow_pin,
  input wire logic [7:0] pat,
  input wire logic clr,
  input wire logic od,
  output logic ow_in,
  output logic wbit
);
  import owb_pkg::*;
  logic dl, dl_q;
  logic [2:0] n;
  logic [7:0] hold;
  logic [11:0] lo;
  assign dl = ow_pin.oe && !ow_pin.o;
  // The line has a pull-up, so a released line reads high.
  assign ow_in = !(dl || hold != 8'h00);
  always_ff @(posedge sys_clk)
  begin
    dl_q <= dl;
    lo <= dl ? lo + 12'h001 : 12'h000;
    if (hold != 8'h00)
      hold <= hold - 8'h1;
    if (clr)
    begin
      n <= 3'h0;
      hold <= 8'h00;
      wbit <= 1'b0;
    end
    else if (dl && !dl_q)
    begin
      n <= n + 3'h1;
      // A zero answer holds past the sample point.
      if (!pat[n])
        hold <= od ? 8'd150 : 8'd30;
    end
    else if (dl_q && !dl)
      wbit <= lo < (od ? 12'd150 : 12'd30);
  end
endmodule
`default_nettype wire

// ### dv/testbench.sv
// Self-checking bench of the read-byte and triplet engine.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import owb_pkg::*;
  logic sys_clk, rst_n, scl, sda, clr, ack, ow_in, wbit, cmd_ack, busy, r0, r1, dv, d, pu, od;
  owb_req_t req;
  owb_pin_t ow_pin;
  logic [7:0] rdata, pat, v;
  logic [2:0] tc [5] = '{3'b000, 3'b100, 3'b110, 3'b001, 3'b011};
  int n_fail = 0;
  int n_checks = 0;
  int k;
  owb_engine #(.SLOT_STD_NS(2000), .LOW1_STD_NS(200), .LOW0_STD_NS(1500), .SMP_STD_NS(500), .APU_NS(100)) dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .req(req), .rdata(rdata), .cmd_ack(cmd_ack), .busy(busy),
    .scl_in(scl), .sda_in(sda), .ow_in(ow_in), .ow_pin(ow_pin));
  owb_slave far (.sys_clk(sys_clk), .ow_pin(ow_pin), .pat(pat), .clr(clr), .od(od), .ow_in(ow_in),
    .wbit(wbit));
  always @(posedge sys_clk)
    pu <= clr ? 1'b0 : (pu | (ow_pin.oe & ow_pin.o));
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] dat);
    @(posedge sys_clk) req <= {a, dat, 2'b10};
    @(posedge sys_clk) req <= '0;
    #1 ack = cmd_ack;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge sys_clk) req <= {a, 8'h00, 2'b01};
    @(posedge sys_clk) req <= '0;
    #1 v = rdata;
  endtask
  task automatic host_bit(input logic b);
    @(posedge sys_clk) scl <= 1'b0;
    sda <= b;
    repeat (4) @(posedge sys_clk);
    scl <= 1'b1;
    repeat (4) @(posedge sys_clk);
    scl <= 1'b0;
  endtask
  task automatic idle();
    for (k = 0; k < 4000 && busy !== 1'b0; k++)
    begin
      @(posedge sys_clk);
      #1;
    end
    chk("idle", {7'h0, busy}, 8'h00);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (40000) @(posedge sys_clk);
    n_fail++;
    print_verdict();
  end
  initial
  begin
    rst_n = 1'b0;
    scl = 1'b1;
    sda = 1'b1;
    clr = 1'b1;
    od = 1'b0;
    pat = 8'ha5;
    req = '0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    clr <= 1'b0;
    rd(3'h4);
    chk("stat", v, 8'h00);
    wr(3'h0, 8'h96);
    chk("ack", {7'h0, ack}, 8'h01);
    host_bit(1'b1);
    repeat (6) @(posedge sys_clk);
    #1 chk("busy", {7'h0, busy}, 8'h01);
    wr(3'h0, 8'h96);
    chk("ack", {7'h0, ack}, 8'h00);
    wr(3'h0, 8'h78);
    chk("ack", {7'h0, ack}, 8'h00);
    rd(3'h2);
    chk("poll", v & 8'h01, 8'h01);
    rd(3'h2);
    chk("poll", v & 8'h01, 8'h01);
    idle();
    rd(3'h2);
    chk("poll", v & 8'h01, 8'h00);
    wr(3'h1, 8'h01);
    rd(3'h2);
    chk("byte", v, 8'ha5);
    wr(3'h1, 8'h00);
    $display("test read byte done");
    for (int i = 0; i < 64; i++)
    begin
      {dv, r1, r0} = tc[i % 5];
      d = (r0 != r1) ? r0 : (r0 | dv);
      @(posedge sys_clk) pat <= {6'h3f, r1, r0};
      clr <= 1'b1;
      @(posedge sys_clk) clr <= 1'b0;
      wr(3'h0, 8'h78);
      chk("ack", {7'h0, ack}, 8'h01);
      host_bit(dv);
      repeat (6) @(posedge sys_clk);
      #1 chk("busy", {7'h0, busy}, 8'h01);
      repeat (7) host_bit(~dv);
      host_bit(1'b1);
      idle();
      chk("write", {7'h0, wbit}, {7'h0, d});
      rd(3'h2);
      chk("trip", v & 8'he1, {d, r1, r0, 5'h00});
    end
    chk("pullup", {7'h0, pu}, 8'h00);
    $display("test triplet done");
    wr(3'h3, 8'h03);
    rd(3'h3);
    chk("cfg", v, 8'h03);
    @(posedge sys_clk) pat <= 8'h3c;
    od <= 1'b1;
    clr <= 1'b1;
    @(posedge sys_clk) clr <= 1'b0;
    wr(3'h0, 8'h96);
    chk("ack", {7'h0, ack}, 8'h01);
    host_bit(1'b1);
    repeat (6) @(posedge sys_clk);
    #1 chk("busy", {7'h0, busy}, 8'h01);
    idle();
    wr(3'h1, 8'h01);
    rd(3'h2);
    chk("od byte", v, 8'h3c);
    chk("pullup", {7'h0, pu}, 8'h01);
    $display("test speed and pullup done");
    print_verdict();
  end
endmodule
`default_nettype wire
